// [src/ccse_pkg.sv]
package ccse_pkg;

    // opcode fields of the fetched program word
    localparam logic [5:0]  OPC_COMPLEMENT = 6'h07;
    localparam logic [6:0]  OPC_CMP_EQUAL  = 7'h31;
    localparam int          OPC_C_LSB      = 10;
    localparam int          OPC_Q_LSB      = 9;
    localparam int          DEST_BIT       = 9;
    localparam int          ACCESS_BIT     = 8;

    // banking and indexed literal offset limits
    localparam logic [7:0]  ILO_LIMIT      = 8'h5F;
    localparam logic [3:0]  ACC_LOW_BANK   = 4'h0;
    localparam logic [3:0]  ACC_HIGH_BANK  = 4'hF;

    // reset values
    localparam logic [11:0] ADDR_RST       = 12'h000;
    localparam logic [7:0]  DATA_RST       = 8'h00;

    // quarter-cycle sequencer
    typedef enum logic [3:0] {
        CCSE_Q1 = 4'h1,
        CCSE_Q2 = 4'h2,
        CCSE_Q3 = 4'h4,
        CCSE_Q4 = 4'h8
    } ccse_q_t;

    // instruction in flight
    typedef enum logic [2:0] {
        CCSE_OP_IDLE = 3'h1,
        CCSE_OP_COMP = 3'h2,
        CCSE_OP_CPEQ = 3'h4
    } ccse_op_t;

endpackage : ccse_pkg

// [src/ccse_exec.sv]
`timescale 1ns/100ps

module ccse_exec
    import ccse_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_valid,
    input  wire logic        instr_two_word,
    input  wire logic [7:0]  w_in,
    input  wire logic [3:0]  bank_select_reg,
    input  wire logic        ext_set_en,
    input  wire logic [11:0] index_base,
    input  wire logic [7:0]  mem_rdata,
    output logic             q1_strobe_reg,
    output logic [11:0]      mem_addr_reg,
    output logic             mem_rd_reg,
    output logic             mem_wr_reg,
    output logic [7:0]       mem_wdata_reg,
    output logic             w_wr_reg,
    output logic [7:0]       w_wdata_reg,
    output logic             flag_wr_reg,
    output logic             neg_flag_reg,
    output logic             zero_flag_reg,
    output logic             nop_slot_reg,
    output logic             instr_done_reg
);

    ////////////////////////////////////////////////////////////////////////
    // address resolution

    function automatic logic [11:0] ccse_resolve(
        input logic [7:0]  f,
        input logic        a,
        input logic [3:0]  bank,
        input logic        ext,
        input logic [11:0] base
    );
        logic [11:0] r;
        r = {bank, f};
        if (!a) begin
            if (ext && (f <= ILO_LIMIT)) begin
                r = base + {4'h0, f};
            end else if (f <= ILO_LIMIT) begin
                r = {ACC_LOW_BANK, f};
            end else begin
                r = {ACC_HIGH_BANK, f};
            end
        end
        return r;
    endfunction : ccse_resolve

    ////////////////////////////////////////////////////////////////////////
    // state

    ccse_q_t     q_reg,          q_next;
    ccse_op_t    op_reg,         op_next;
    logic        dest_f_reg,     dest_f_next;
    logic        skip_pend_reg,  skip_pend_next;
    logic        skip_first_reg, skip_first_next;
    logic        q1_strobe_next;
    logic [11:0] mem_addr_next;
    logic        mem_rd_next;
    logic        mem_wr_next;
    logic [7:0]  mem_wdata_next;
    logic        w_wr_next;
    logic [7:0]  w_wdata_next;
    logic        flag_wr_next;
    logic        neg_flag_next;
    logic        zero_flag_next;
    logic        nop_slot_next;
    logic        instr_done_next;

    logic        complement_file_op;
    logic        compare_equal_skip_op;
    logic [7:0]  comp_result;
    logic [7:0]  cmp_diff;

    // decode only counts when the slot is not being flushed by a skip
    assign complement_file_op = instr_valid && !skip_pend_reg &&
        (instr_word[15:OPC_C_LSB] == OPC_COMPLEMENT);
    assign compare_equal_skip_op = instr_valid && !skip_pend_reg &&
        (instr_word[15:OPC_Q_LSB] == OPC_CMP_EQUAL);
    assign comp_result = ~mem_rdata;
    assign cmp_diff    = mem_rdata - w_in;

    always_comb begin
        q_next          = q_reg;
        op_next         = op_reg;
        dest_f_next     = dest_f_reg;
        skip_pend_next  = skip_pend_reg;
        skip_first_next = skip_first_reg;
        mem_addr_next   = mem_addr_reg;
        mem_rd_next     = 1'b0;
        mem_wr_next     = 1'b0;
        mem_wdata_next  = mem_wdata_reg;
        w_wr_next       = 1'b0;
        w_wdata_next    = w_wdata_reg;
        flag_wr_next    = 1'b0;
        neg_flag_next   = neg_flag_reg;
        zero_flag_next  = zero_flag_reg;
        nop_slot_next   = nop_slot_reg;
        instr_done_next = 1'b0;
        case (q_reg)
            CCSE_Q1: begin
                q_next = CCSE_Q2;
                if (skip_pend_reg) begin
                    // fetched word is thrown away, slot runs as a nop
                    op_next         = CCSE_OP_IDLE;
                    nop_slot_next   = 1'b1;
                    skip_first_next = 1'b0;
                    skip_pend_next  = skip_first_reg &&
                                      instr_two_word;
                end else if (complement_file_op) begin
                    op_next       = CCSE_OP_COMP;
                    dest_f_next   = instr_word[DEST_BIT];
                    mem_rd_next   = 1'b1;
                    mem_addr_next = ccse_resolve(instr_word[7:0],
                        instr_word[ACCESS_BIT], bank_select_reg,
                        ext_set_en, index_base);
                end else if (compare_equal_skip_op) begin
                    op_next       = CCSE_OP_CPEQ;
                    mem_rd_next   = 1'b1;
                    mem_addr_next = ccse_resolve(instr_word[7:0],
                        instr_word[ACCESS_BIT], bank_select_reg,
                        ext_set_en, index_base);
                end else begin
                    op_next = CCSE_OP_IDLE;
                end
            end
            CCSE_Q2: begin
                q_next = CCSE_Q3;
            end
            CCSE_Q3: begin
                q_next = CCSE_Q4;
                if (op_reg == CCSE_OP_COMP) begin
                    if (dest_f_reg) begin
                        mem_wr_next    = 1'b1;
                        mem_wdata_next = comp_result;
                    end else begin
                        w_wr_next    = 1'b1;
                        w_wdata_next = comp_result;
                    end
                    flag_wr_next   = 1'b1;
                    neg_flag_next  = comp_result[7];
                    zero_flag_next = (comp_result == DATA_RST);
                end else if (op_reg == CCSE_OP_CPEQ) begin
                    // flags untouched, only the skip is armed
                    if (cmp_diff == DATA_RST) begin
                        skip_pend_next  = 1'b1;
                        skip_first_next = 1'b1;
                    end
                end
            end
            CCSE_Q4: begin
                q_next          = CCSE_Q1;
                instr_done_next = (op_reg != CCSE_OP_IDLE) || nop_slot_reg;
                op_next         = CCSE_OP_IDLE;
                nop_slot_next   = 1'b0;
            end
            default: begin
                q_next        = CCSE_Q1;
                op_next       = CCSE_OP_IDLE;
                nop_slot_next = 1'b0;
            end
        endcase
        q1_strobe_next = (q_next == CCSE_Q1);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg          <= CCSE_Q1;
            op_reg         <= CCSE_OP_IDLE;
            dest_f_reg     <= 1'b0;
            skip_pend_reg  <= 1'b0;
            skip_first_reg <= 1'b0;
            q1_strobe_reg  <= 1'b1;
            mem_addr_reg   <= ADDR_RST;
            mem_rd_reg     <= 1'b0;
            mem_wr_reg     <= 1'b0;
            mem_wdata_reg  <= DATA_RST;
            w_wr_reg       <= 1'b0;
            w_wdata_reg    <= DATA_RST;
            flag_wr_reg    <= 1'b0;
            neg_flag_reg   <= 1'b0;
            zero_flag_reg  <= 1'b0;
            nop_slot_reg   <= 1'b0;
            instr_done_reg <= 1'b0;
        end else begin
            q_reg          <= q_next;
            op_reg         <= op_next;
            dest_f_reg     <= dest_f_next;
            skip_pend_reg  <= skip_pend_next;
            skip_first_reg <= skip_first_next;
            q1_strobe_reg  <= q1_strobe_next;
            mem_addr_reg   <= mem_addr_next;
            mem_rd_reg     <= mem_rd_next;
            mem_wr_reg     <= mem_wr_next;
            mem_wdata_reg  <= mem_wdata_next;
            w_wr_reg       <= w_wr_next;
            w_wdata_reg    <= w_wdata_next;
            flag_wr_reg    <= flag_wr_next;
            neg_flag_reg   <= neg_flag_next;
            zero_flag_reg  <= zero_flag_next;
            nop_slot_reg   <= nop_slot_next;
            instr_done_reg <= instr_done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic        any_hit;
    logic [11:0] ilo_sum;
    assign any_hit = (q_reg == CCSE_Q1) &&
                     (complement_file_op || compare_equal_skip_op);
    assign ilo_sum = index_base + {4'h0, instr_word[7:0]};

    sequence comp_decode_s;
        (q_reg == CCSE_Q1) && complement_file_op;
    endsequence

    sequence cmp_equal_s;
        (q_reg == CCSE_Q3) && (op_reg == CCSE_OP_CPEQ) &&
        (mem_rdata == w_in);
    endsequence

    sequence nop_cycle_s;
        nop_slot_reg && !mem_rd_reg && !mem_wr_reg && !w_wr_reg;
    endsequence

    comp_inverse_a: assert property (
        (mem_wr_reg || w_wr_reg) && (op_reg == CCSE_OP_COMP) |->
        (mem_wr_reg ? mem_wdata_reg : w_wdata_reg) == ~$past(mem_rdata))
        else $error("complement result is not the inverse");

    comp_dest_a: assert property (
        (q_reg == CCSE_Q4) && (op_reg == CCSE_OP_COMP) |->
        (mem_wr_reg == dest_f_reg) && (w_wr_reg == !dest_f_reg))
        else $error("complement written to wrong destination");

    bank_addr_a: assert property (
        any_hit && instr_word[ACCESS_BIT] |=>
        mem_addr_reg == {$past(bank_select_reg), $past(instr_word[7:0])})
        else $error("banked address wrong");

    ilo_addr_a: assert property (
        any_hit && !instr_word[ACCESS_BIT] && ext_set_en &&
        (instr_word[7:0] <= ILO_LIMIT) |=> mem_addr_reg == $past(ilo_sum))
        else $error("indexed literal offset address wrong");

    cmp_flags_a: assert property (
        (op_reg == CCSE_OP_CPEQ) |-> !flag_wr_reg && $stable(neg_flag_reg)
        && $stable(zero_flag_reg))
        else $error("compare touched the flags");

    skip_nop_a: assert property (
        cmp_equal_s |-> ##3 nop_cycle_s [*3] ##1 instr_done_reg)
        else $error("equal compare did not flush next instruction");

    skip_two_a: assert property (
        (q_reg == CCSE_Q1) && skip_pend_reg && skip_first_reg &&
        instr_two_word |-> ##5 nop_cycle_s [*3])
        else $error("second word of skipped instruction not flushed");

    neq_nowrite_a: assert property (
        (q_reg == CCSE_Q3) && (op_reg == CCSE_OP_CPEQ) &&
        (mem_rdata != w_in) |=>
        (!mem_wr_reg && !w_wr_reg && !skip_pend_reg) [*2])
        else $error("unequal compare wrote or skipped");

    comp_cycle_a: assert property (
        comp_decode_s |-> ##1 mem_rd_reg ##1 !mem_rd_reg ##1
        (mem_wr_reg || w_wr_reg) && flag_wr_reg ##1 instr_done_reg)
        else $error("complement did not finish in one cycle");

    nz_flags_a: assert property (
        flag_wr_reg |-> (zero_flag_reg == ($past(mem_rdata) == 8'hFF)) &&
        (neg_flag_reg == !$past(mem_rdata[7])))
        else $error("negative or zero flag wrong");

endmodule : ccse_exec

// [test/ccse_dmem.sv]
`timescale 1ns/100ps

// data memory beside the block: one cycle read latency
module ccse_dmem (
    input  wire logic        mclk,
    input  wire logic [11:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [4096];

    initial mem_rdata = 8'hA5;

    always @(posedge mclk) begin
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
        // read bus toggles outside its window so stale data never matches
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    end
endmodule : ccse_dmem

// [test/testbench.sv]
`timescale 1ns/100ps

module testbench;
    import ccse_pkg::*;
    logic        mclk, rst_n, instr_valid, instr_two_word, ext_set_en;
    logic [15:0] instr_word;
    logic [7:0]  w_in, mem_rdata, mem_wdata_reg, w_wdata_reg;
    logic [3:0]  bank_select_reg;
    logic [11:0] index_base, mem_addr_reg;
    logic        q1_strobe_reg, mem_rd_reg, mem_wr_reg, w_wr_reg;
    logic        flag_wr_reg, neg_flag_reg, zero_flag_reg;
    logic        nop_slot_reg, instr_done_reg;
    logic        s_rd, s_wr, s_wwr, s_flg, s_done;
    logic [7:0]  s_wd, s_wwd;
    logic [11:0] s_ad;
    int          fails, n_tests;

    ccse_exec ccse_exec_i (.mclk, .rst_n, .instr_word, .instr_valid,
        .instr_two_word, .w_in, .bank_select_reg, .ext_set_en, .index_base,
        .mem_rdata, .q1_strobe_reg, .mem_addr_reg, .mem_rd_reg, .mem_wr_reg,
        .mem_wdata_reg, .w_wr_reg, .w_wdata_reg, .flag_wr_reg, .neg_flag_reg,
        .zero_flag_reg, .nop_slot_reg, .instr_done_reg);

    ccse_dmem ccse_dmem_i (.mclk, .mem_addr(mem_addr_reg),
        .mem_rd(mem_rd_reg), .mem_wr(mem_wr_reg),
        .mem_wdata(mem_wdata_reg), .mem_rdata);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [11:0] e, g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one instruction cycle, strobes captured in the quarter they stand
    task automatic issue(input logic [15:0] word, input logic [7:0] w);
        for (int i = 0; i < 8 && q1_strobe_reg !== 1'b1; i++)
            @(posedge mclk) #1;
        chk("q1_strobe", 1, q1_strobe_reg);
        instr_word = word;
        instr_valid = 1'b1;
        w_in = w;
        @(posedge mclk) #1;
        instr_valid = 1'b0;
        s_rd = mem_rd_reg;
        s_ad = mem_addr_reg;
        chk("q1_strobe", 0, q1_strobe_reg);
        repeat (2) @(posedge mclk) #1;
        s_wr = mem_wr_reg;
        s_wwr = w_wr_reg;
        s_flg = flag_wr_reg;
        s_wd = mem_wdata_reg;
        s_wwd = w_wdata_reg;
        @(posedge mclk) #1;
        s_done = instr_done_reg;
    endtask : issue

    ////////////////////////////////////////////////////////////////////////
    task automatic comp_case(input logic a, e, input logic [7:0] f,
                             input logic [11:0] ea);
        logic [7:0] v;
        logic [7:0] nv;
        v = ea[7:0] ^ 8'h5A;
        nv = ~v;
        ccse_dmem_i.mem[ea] = v;
        ext_set_en = e;
        issue({OPC_COMPLEMENT, 1'b1, a, f}, 8'h00);
        chk("addr", ea, s_ad);
        chk("rd", 1, s_rd);
        chk("wr", 1, s_wr);
        chk("w_wr", 0, s_wwr);
        chk("wdata", nv, s_wd);
        chk("mem", nv, ccse_dmem_i.mem[ea]);
        chk("flag_wr", 1, s_flg);
        chk("neg", nv[7], neg_flag_reg);
        chk("zero", nv == 8'h00, zero_flag_reg);
        chk("done", 1, s_done);
    endtask : comp_case

    task automatic t_addr;
        comp_case(1'b1, 1'b0, 8'hA5, 12'h3A5);
        comp_case(1'b0, 1'b0, 8'h20, 12'h020);
        comp_case(1'b0, 1'b0, 8'hF0, 12'hFF0);
        comp_case(1'b0, 1'b1, 8'h5F, 12'h04F);
        comp_case(1'b0, 1'b1, 8'h60, 12'hF60);
        comp_case(1'b1, 1'b1, 8'h10, 12'h310);
    endtask : t_addr

    task automatic t_dest_w;
        ccse_dmem_i.mem[12'h377] = 8'hFF;
        issue({OPC_COMPLEMENT, 1'b0, 1'b1, 8'h77}, 8'h00);
        chk("w_wr", 1, s_wwr);
        chk("wr", 0, s_wr);
        chk("w_wdata", 0, s_wwd);
        chk("mem", 12'h0FF, ccse_dmem_i.mem[12'h377]);
        chk("zero", 1, zero_flag_reg);
        chk("neg", 0, neg_flag_reg);
    endtask : t_dest_w

    task automatic t_cmp_ne;
        issue({OPC_CMP_EQUAL, 1'b1, 8'h77}, 8'hFE);
        chk("rd", 1, s_rd);
        chk("wr", 0, s_wr | s_wwr);
        chk("flag_wr", 0, s_flg);
        chk("zero", 1, zero_flag_reg);
        chk("done", 1, s_done);
        chk("nop", 0, nop_slot_reg);
    endtask : t_cmp_ne

    // equal compare, then a complement word that must be thrown away
    task automatic t_skip(input logic two);
        int nops;
        int acts;
        nops = 0;
        acts = 0;
        issue({OPC_CMP_EQUAL, 1'b1, 8'h77}, 8'hFF);
        chk("done", 1, s_done);
        instr_word = {OPC_COMPLEMENT, 1'b1, 1'b1, 8'h77};
        instr_valid = 1'b1;
        instr_two_word = two;
        for (int k = 1; k <= (two ? 8 : 4); k++) begin
            @(posedge mclk) #1;
            instr_valid = 1'b0;
            instr_two_word = 1'b0;
            nops += nop_slot_reg;
            acts += mem_rd_reg | mem_wr_reg | w_wr_reg;
        end
        chk("nops", two ? 6 : 3, nops);
        chk("acts", 0, acts);
        chk("done", 1, instr_done_reg);
        chk("mem", 12'h0FF, ccse_dmem_i.mem[12'h377]);
    endtask : t_skip

    task automatic t_refuse;
        issue(16'h6A77, 8'h00);
        chk("rd", 0, s_rd);
        chk("done", 0, s_done);
    endtask : t_refuse

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #5000;
        fails++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        instr_word = 16'h0000;
        instr_valid = 1'b0;
        instr_two_word = 1'b0;
        w_in = 8'h00;
        bank_select_reg = 4'h3;
        ext_set_en = 1'b0;
        index_base = 12'hFF0;
        repeat (2) @(posedge mclk);
        #1 rst_n = 1'b1;
        t_addr();
        t_dest_w();
        t_cmp_ne();
        t_skip(1'b0);
        t_skip(1'b1);
        t_refuse();
        stop_test();
    end
endmodule : testbench
